// File: hdl/sfs_pkg.sv
// Constants, types and register layout of the supply fault supervisor.
package sfs_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int BATT_FILT_NS = 10000;
    localparam int BATT_FILT_CYC =
        (BATT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IO_SC_NS = 10000;
    localparam int IO_SC_CYC = (IO_SC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_DELAY_NS = 10000;
    localparam int RESET_DELAY_CYC =
        (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD_MS = 1000;
    localparam int MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD_CYC = MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [2:0] RPT_UV_LAST = 3'h3;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_LIVE = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0c;

    localparam int CTRL_W = 11;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
    localparam int C_BMON_EN = 0;
    localparam int C_BTHR_LSB = 1;
    localparam int C_BST_CUT = 3;
    localparam int C_OV_RST = 4;
    localparam int C_EXT_ON = 5;
    localparam int C_BST_EN = 6;
    localparam int C_CAN_LSB = 7;

    localparam int FLAG_W = 17;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 17'h00000;
    localparam int F_BATT = 0;
    localparam int F_BCUT = 1;
    localparam int F_WARN = 2;
    localparam int F_IOUV = 3;
    localparam int F_RPTFS = 4;
    localparam int F_IOOV = 5;
    localparam int F_SC = 6;
    localparam int F_REGUV = 7;
    localparam int F_EXTOT = 8;
    localparam int F_PERIPH = 9;
    localparam int F_MAINSD = 10;
    localparam int F_MAINOT = 11;
    localparam int F_BOOT = 12;
    localparam int F_CANF_LSB = 13;

    localparam int CMD_MODE_LSB = 0;
    localparam int CMD_MODE_GO = 2;
    localparam int CMD_SOFT_RST = 3;
    localparam logic [1:0] REQ_NORMAL = 2'h0;
    localparam logic [1:0] REQ_STOP = 2'h1;
    localparam logic [1:0] REQ_SLEEP = 2'h2;

    typedef enum logic [5:0] {
        MODE_INIT = 6'h01,
        MODE_NORMAL = 6'h02,
        MODE_STOP = 6'h04,
        MODE_SLEEP = 6'h08,
        MODE_RESTART = 6'h10,
        MODE_FAILSAFE = 6'h20
    } sfs_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sfs_apb_req_t;

    typedef struct packed {
        logic batt_below;
        logic boost_off_cross;
        logic boost_on_cross;
        logic io_warn;
        logic io_uv;
        logic io_ov;
        logic vs_uv;
        logic ext_reg_uv;
        logic main_reg_uv;
        logic reg_ramping;
        logic ext_tsd;
        logic main_tsd;
        logic boost_tsd;
        logic [3:0] can_tsd;
        logic wake;
    } sfs_fault_t;

endpackage : sfs_pkg

// File: hdl/sfs_supervisor.sv
// Supply fault supervisor: battery, I/O supply, regulator and thermal faults.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps

// Functional notes
// - Filtered battery-low crossing sets the latched flag and pulls interrupt low.
// - Software clears the battery-low latch only once battery is above threshold.
// - A live bit mirrors the battery comparator output.
// - Monitoring runs when enabled in Normal, Stop or Restart; four thresholds.
// - The battery comparator is debounced for a fixed filter time.
// - Cutoff enabled and off-threshold crossed: boost off, cutoff flag set.
// - Boost returns at the on-threshold; cutoff flag stays until cleared.
// - I/O prewarning only sets its warning flag.
// - I/O undervoltage: reset low, flag set, Restart; only the flag in Fail-Safe, nothing in Sleep.
// - Count consecutive I/O undervoltage in Init, Normal, Stop with main supply good.
// - Fourth consecutive undervoltage enters Fail-Safe and sets its flag.
// - Counter clears on Fail-Safe entry, undervoltage flag clear or soft reset.
// - Overvoltage, reset bit, config 1/3: Restart, fail on, back to Normal.
// - Overvoltage, reset bit, config 2/4: Fail-Safe and fail output on.
// - Overvoltage without reset bit only sets the overvoltage flag.
// - Long I/O undervoltage: short flag, Fail-Safe, main regulator off; external one too with config pin high.
// - Short-circuit Fail-Safe is left only on a wake event.
// - Regulator undervoltage flag per config pin, not during ramping, cleared by software.
// - External regulator overheat clears its on bit and sets two flags.
// - CAN overheat turns off only that transmitter and sets its flags.
// - Main regulator overheat: Fail-Safe held for the hold time, wake sources on.
// - Boost overheat clears boost enable; shutdown flags clear after condition.
module sfs_supervisor #(
    parameter int unsigned MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD = sfs_pkg::MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire sfs_pkg::sfs_apb_req_t apb_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    input wire sfs_pkg::sfs_fault_t fault_i,
    input wire logic supply_config_pin_i,
    input wire logic [1:0] sys_config_i,
    output logic interrupt_out_n_o,
    output logic reset_out_n_o,
    output logic fail_output_o,
    output logic boost_en_o,
    output logic main_regulator_en_o,
    output logic external_regulator_en_o,
    output logic [3:0] can_tx_en_o,
    output logic wake_src_en_o,
    output logic [1:0] battery_threshold_select_o,
    output logic [5:0] mode_o
);
    import sfs_pkg::*;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ADDR_CTRL) || (a == ADDR_FLAGS) ||
                 (a == ADDR_LIVE) || (a == ADDR_CMD);
    endfunction : mapped

    sfs_mode_t mode;
    sfs_mode_t next_mode;
    logic [CTRL_W-1:0] ctrl;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clr;
    logic battery_low_live;
    logic batt_filt;
    logic [15:0] filt_cnt;
    logic cut_act;
    logic io_uv_q;
    logic io_ov_q;
    logic io_warn_q;
    logic [2:0] rpt_cnt;
    logic [15:0] sc_cnt;
    logic sc_done;
    logic main_off;
    logic fo_latch;
    logic [31:0] rd_cnt;
    logic [31:0] hold_cnt;
    logic acc;
    logic wr;
    logic mon_on;
    logic filt_rise;
    logic uv_ev;
    logic ov_ev;
    logic cnt_ok;
    logic rpt_fs;
    logic sc_ev;
    logic ov_rst_hit;
    logic ov_fs;
    logic ov_restart;
    logic go_fs;
    logic go_rst;
    logic soft_rst;
    logic cmd_go;
    logic uv_clr_eff;
    logic hold_done;
    logic reg_uv_src;
    logic periph_tsd;
    logic mainsd_cond;

    assign acc = apb_i.psel && apb_i.penable;
    assign wr = acc && apb_i.pwrite;
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped(apb_i.paddr);
    assign cmd_go = wr && apb_i.paddr == ADDR_CMD &&
                    apb_i.pwdata[CMD_MODE_GO];
    assign soft_rst = wr && apb_i.paddr == ADDR_CMD &&
                      apb_i.pwdata[CMD_SOFT_RST];

    // Read data is captured in the setup phase so pready can stay high.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            prdata_o <= 32'h0000_0000;
        else if (apb_i.psel && !apb_i.penable)
        begin
            unique case (apb_i.paddr)
                ADDR_CTRL: prdata_o <= {21'h000000, ctrl};
                ADDR_FLAGS: prdata_o <= {15'h0000, flags};
                ADDR_LIVE: prdata_o <= {22'h000000, mode, rpt_cnt,
                                        battery_low_live};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    assign mon_on = ctrl[C_BMON_EN] &&
        (mode == MODE_NORMAL || mode == MODE_STOP || mode == MODE_RESTART);

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            battery_low_live <= 1'b0;
        else
            battery_low_live <= fault_i.batt_below;
    end

    // The filter restarts on every bounce, so a chattering comparator never
    // raises an interrupt until it settles for the full filter time.
    assign filt_rise = mon_on && fault_i.batt_below && !batt_filt &&
                       filt_cnt == 16'(BATT_FILT_CYC - 1);
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            batt_filt <= 1'b0;
            filt_cnt <= 16'h0000;
        end
        else if (!mon_on)
        begin
            batt_filt <= 1'b0;
            filt_cnt <= 16'h0000;
        end
        else if (fault_i.batt_below == batt_filt)
            filt_cnt <= 16'h0000;
        else if (filt_cnt == 16'(BATT_FILT_CYC - 1))
        begin
            batt_filt <= fault_i.batt_below;
            filt_cnt <= 16'h0000;
        end
        else
            filt_cnt <= filt_cnt + 16'h0001;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cut_act <= 1'b0;
        else if (ctrl[C_BST_CUT] && fault_i.boost_off_cross)
            cut_act <= 1'b1;
        else if (fault_i.boost_on_cross)
            cut_act <= 1'b0;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            io_uv_q <= 1'b0;
            io_ov_q <= 1'b0;
            io_warn_q <= 1'b0;
        end
        else
        begin
            io_uv_q <= fault_i.io_uv;
            io_ov_q <= fault_i.io_ov;
            io_warn_q <= fault_i.io_warn;
        end
    end

    assign uv_ev = fault_i.io_uv && !io_uv_q && mode != MODE_SLEEP;
    assign ov_ev = fault_i.io_ov && !io_ov_q;
    assign cnt_ok = !fault_i.vs_uv && (mode == MODE_INIT ||
                    mode == MODE_NORMAL || mode == MODE_STOP);
    assign rpt_fs = uv_ev && cnt_ok && rpt_cnt == RPT_UV_LAST;
    assign ov_rst_hit = ov_ev && ctrl[C_OV_RST];
    assign ov_fs = ov_rst_hit && sys_config_i[0];
    assign ov_restart = ov_rst_hit && !sys_config_i[0];

    // Short-circuit timing needs the main supply and, when the config pin is
    // high, the main regulator to be good, else it would misfire on ramp.
    assign sc_ev = sc_cnt == 16'(IO_SC_CYC - 1) && !sc_done;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sc_cnt <= 16'h0000;
            sc_done <= 1'b0;
        end
        else if (!fault_i.io_uv || fault_i.vs_uv ||
                 (supply_config_pin_i && fault_i.main_reg_uv))
        begin
            sc_cnt <= 16'h0000;
            sc_done <= 1'b0;
        end
        else if (sc_ev)
            sc_done <= 1'b1;
        else if (!sc_done)
            sc_cnt <= sc_cnt + 16'h0001;
    end

    assign go_fs = rpt_fs || sc_ev || ov_fs || fault_i.main_tsd;
    assign go_rst = uv_ev || ov_restart;

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rpt_cnt <= 3'h0;
        else if ((go_fs && mode != MODE_FAILSAFE) || uv_clr_eff || soft_rst)
            rpt_cnt <= 3'h0;
        else if (uv_ev && cnt_ok)
            rpt_cnt <= rpt_cnt + 3'h1;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            hold_cnt <= 32'(MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD);
        else if (fault_i.main_tsd)
            hold_cnt <= 32'h0000_0000;
        else if (!hold_done)
            hold_cnt <= hold_cnt + 32'h0000_0001;
    end
    assign hold_done = hold_cnt == 32'(MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD);

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_cnt <= 32'h0000_0000;
        else if (mode != MODE_RESTART || go_rst)
            rd_cnt <= 32'h0000_0000;
        else if (rd_cnt != 32'(RESET_DELAY_CYC))
            rd_cnt <= rd_cnt + 32'h0000_0001;
    end

    always_comb
    begin
        next_mode = mode;
        if (go_fs)
            next_mode = MODE_FAILSAFE;
        else if (mode == MODE_FAILSAFE)
        begin
            if (fault_i.wake && hold_done)
                next_mode = MODE_RESTART;
        end
        else if (go_rst)
            next_mode = MODE_RESTART;
        else
        begin
            unique case (mode)
                MODE_RESTART:
                    if (rd_cnt == 32'(RESET_DELAY_CYC) && !fault_i.io_uv)
                        next_mode = MODE_NORMAL;
                MODE_SLEEP:
                    if (fault_i.wake)
                        next_mode = MODE_RESTART;
                MODE_INIT, MODE_NORMAL, MODE_STOP:
                    if (cmd_go)
                    begin
                        unique case (apb_i.pwdata[CMD_MODE_LSB +: 2])
                            REQ_NORMAL: next_mode = MODE_NORMAL;
                            REQ_STOP: next_mode = MODE_STOP;
                            REQ_SLEEP:
                                if (mode != MODE_INIT)
                                    next_mode = MODE_SLEEP;
                            default: next_mode = mode;
                        endcase
                    end
                default: next_mode = mode;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode <= MODE_INIT;
            reset_out_n_o <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            reset_out_n_o <= next_mode != MODE_RESTART &&
                             next_mode != MODE_INIT;
        end
    end

    // Software enables are writable; hardware clears win the same cycle.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctrl <= CTRL_RESET;
        else
        begin
            if (wr && apb_i.paddr == ADDR_CTRL)
                ctrl <= apb_i.pwdata[CTRL_W-1:0];
            if (ov_restart)
                ctrl[C_OV_RST] <= 1'b0;
            if (fault_i.ext_tsd)
                ctrl[C_EXT_ON] <= 1'b0;
            if (fault_i.boost_tsd)
                ctrl[C_BST_EN] <= 1'b0;
        end
    end

    assign reg_uv_src = supply_config_pin_i ? fault_i.main_reg_uv
                                            : fault_i.ext_reg_uv;
    assign periph_tsd = (fault_i.ext_tsd && !supply_config_pin_i) ||
                        fault_i.boost_tsd || (|fault_i.can_tsd);
    assign mainsd_cond = fault_i.main_tsd ||
                         (fault_i.ext_tsd && supply_config_pin_i);

    always_comb
    begin
        flag_set = '0;
        flag_set[F_BATT] = filt_rise;
        flag_set[F_BCUT] = ctrl[C_BST_CUT] && fault_i.boost_off_cross;
        flag_set[F_WARN] = fault_i.io_warn && !io_warn_q &&
                           mode != MODE_SLEEP;
        flag_set[F_IOUV] = uv_ev;
        flag_set[F_RPTFS] = rpt_fs;
        flag_set[F_IOOV] = ov_ev;
        flag_set[F_SC] = sc_ev;
        flag_set[F_REGUV] = reg_uv_src && !fault_i.reg_ramping;
        flag_set[F_EXTOT] = fault_i.ext_tsd;
        flag_set[F_PERIPH] = periph_tsd;
        flag_set[F_MAINSD] = mainsd_cond;
        flag_set[F_MAINOT] = fault_i.main_tsd;
        flag_set[F_BOOT] = fault_i.boost_tsd;
        flag_set[F_CANF_LSB +: 4] = fault_i.can_tsd;
        flag_clr = '0;
        if (wr && apb_i.paddr == ADDR_FLAGS)
            flag_clr = apb_i.pwdata[FLAG_W-1:0];
        if (fault_i.batt_below)
            flag_clr[F_BATT] = 1'b0;
        if (periph_tsd)
            flag_clr[F_PERIPH] = 1'b0;
        if (mainsd_cond)
            flag_clr[F_MAINSD] = 1'b0;
    end

    assign uv_clr_eff = flag_clr[F_IOUV] && !flag_set[F_IOUV];

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            flags <= FLAGS_RESET;
        else
            flags <= (flags & ~flag_clr) | flag_set;
    end

    // The fail output raised by an overvoltage reset stays on until software
    // acknowledges the overvoltage flag.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fo_latch <= 1'b0;
            main_off <= 1'b0;
        end
        else
        begin
            if (ov_rst_hit)
                fo_latch <= 1'b1;
            else if (flag_clr[F_IOOV] && !ov_ev)
                fo_latch <= 1'b0;
            if (sc_ev)
                main_off <= 1'b1;
            else if (mode == MODE_FAILSAFE && next_mode != MODE_FAILSAFE)
                main_off <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fail_output_o <= 1'b0;
            boost_en_o <= 1'b0;
            main_regulator_en_o <= 1'b1;
            external_regulator_en_o <= 1'b0;
            can_tx_en_o <= 4'h0;
            wake_src_en_o <= 1'b0;
            interrupt_out_n_o <= 1'b1;
            battery_threshold_select_o <= 2'h0;
        end
        else
        begin
            fail_output_o <= next_mode == MODE_FAILSAFE ||
                             ov_rst_hit || fo_latch;
            boost_en_o <= ctrl[C_BST_EN] && !fault_i.boost_tsd &&
                          !(cut_act || flag_set[F_BCUT]);
            main_regulator_en_o <= !(main_off || sc_ev);
            external_regulator_en_o <= ctrl[C_EXT_ON] &&
                !fault_i.ext_tsd &&
                !(supply_config_pin_i && (main_off || sc_ev));
            can_tx_en_o <= ctrl[C_CAN_LSB +: 4] & ~fault_i.can_tsd;
            wake_src_en_o <= next_mode == MODE_FAILSAFE;
            interrupt_out_n_o <= !(flags[F_BATT] || filt_rise);
            battery_threshold_select_o <= ctrl[C_BTHR_LSB +: 2];
        end
    end

    assign mode_o = mode;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ov_restart;
        ov_restart && !rpt_fs && !sc_ev && !fault_i.main_tsd;
    endsequence
    sequence s_back_normal;
        mode == MODE_RESTART ##1 mode == MODE_NORMAL;
    endsequence

    AST_BATT_INT: assert property (
        filt_rise |=> !interrupt_out_n_o && flags[F_BATT])
        else $error("battery low did not latch or interrupt");
    AST_BATT_HOLD: assert property (
        flags[F_BATT] && fault_i.batt_below |=> flags[F_BATT])
        else $error("battery latch cleared while still low");
    AST_BATT_FILT: assert property (
        $rose(batt_filt) |-> $past(fault_i.batt_below, 2) &&
        $past(filt_cnt) == 16'(BATT_FILT_CYC - 1))
        else $error("battery filter ended early");
    AST_UV_RST: assert property (
        uv_ev && !go_fs |=> mode == MODE_RESTART && !reset_out_n_o)
        else $error("undervoltage did not restart");
    AST_FOURTH: assert property (
        rpt_fs |=> mode == MODE_FAILSAFE && flags[F_RPTFS] && rpt_cnt == 3'h0)
        else $error("fourth undervoltage not handled");
    AST_OV_RST: assert property (
        s_ov_restart |=> mode == MODE_RESTART && fail_output_o &&
        !ctrl[C_OV_RST])
        else $error("overvoltage restart reaction wrong");
    AST_OV_BACK: assert property (
        s_back_normal |-> $past(rd_cnt) == 32'(RESET_DELAY_CYC))
        else $error("restart left before the reset delay");
    AST_OV_FS: assert property (
        ov_fs |=> mode == MODE_FAILSAFE && fail_output_o)
        else $error("overvoltage fail-safe reaction wrong");
    AST_OV_ONLY: assert property (
        ov_ev && !ctrl[C_OV_RST] && !go_fs && !go_rst && !cmd_go &&
        mode != MODE_RESTART && mode != MODE_SLEEP && !fo_latch
        |=> $stable(mode) && !fail_output_o && flags[F_IOOV])
        else $error("plain overvoltage changed more than the flag");
    AST_MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD: assert property (
        mode == MODE_FAILSAFE && !hold_done |=> mode == MODE_FAILSAFE)
        else $error("fail-safe left inside the thermal hold time");

endmodule : sfs_supervisor

// File: verif/sfs_mcu_model.sv
// Microcontroller model: the APB master that reaches the supervisor.
`timescale 1ns/10ps
module sfs_mcu_model (
    input wire logic sys_clk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output sfs_pkg::sfs_apb_req_t apb_o
);
    int tmo = 0;
    logic err = 1'b0;
    initial apb_o = '0;
    // The request stands unchanged until pready is sampled high or 50 access cycles have passed.
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] q);
        int k;
        k = 0;
        @(posedge sys_clk_i);
        apb_o <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: d};
        @(posedge sys_clk_i);
        apb_o.penable <= 1'b1;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end
        while (pready_i !== 1'b1 && k < 50);
        if (k >= 50)
            tmo++;
        q = prdata_i;
        err = pslverr_i;
        apb_o <= '0;
    endtask : xfer
endmodule : sfs_mcu_model

// File: verif/test_supply_fault_supervisor.sv
// Self-checking bench of the supply fault supervisor.
`timescale 1ns/10ps
module test_supply_fault_supervisor;
    import sfs_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    sfs_pkg::sfs_apb_req_t apb;
    sfs_pkg::sfs_fault_t flt = '0;
    logic [1:0] cfg = 2'h0;
    logic pready, pslverr, int_n, rst_n, fail;
    logic [31:0] prdata, v;
    logic [5:0] mode;
    logic boost_en, mreg, xreg, wake_en;
    logic supply_config_pin = 1'b0;
    logic [3:0] can_en;
    int fails = 0;
    int n_tests = 0;
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    sfs_supervisor #(.MAIN_SUPPLY_SHUTDOWN_FLAG_HOLD(20)) DUT (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .apb_i(apb),
        .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
        .fault_i(flt), .supply_config_pin_i(supply_config_pin), .sys_config_i(cfg),
        .interrupt_out_n_o(int_n), .reset_out_n_o(rst_n),
        .fail_output_o(fail), .boost_en_o(boost_en),
        .main_regulator_en_o(mreg), .external_regulator_en_o(xreg),
        .can_tx_en_o(can_en), .wake_src_en_o(wake_en),
        .battery_threshold_select_o(), .mode_o(mode));
    sfs_mcu_model mcu (.sys_clk_i(sys_clk_i), .pready_i(pready),
        .pslverr_i(pslverr), .prdata_i(prdata), .apb_o(apb));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : wt
    task rd(input logic [7:0] a);
        mcu.xfer(1'b0, a, 32'h0, v);
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d);
        mcu.xfer(1'b1, a, d, v);
    endtask : wr
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        wt(10);
        rst_i <= 1'b0;
        wt(1);
        chk("mode", mode, MODE_INIT);
        rd(8'h10);
        chk("slverr", mcu.err, 1'b1);
        wr(ADDR_CMD, 32'h4);
        wt(2);
        chk("mode", mode, MODE_NORMAL);
        wr(ADDR_CTRL, 32'h1);
        flt.batt_below <= 1'b1;
        wt(BATT_FILT_CYC - 10);
        chk("int_n", int_n, 1'b1);
        wt(20);
        chk("int_n", int_n, 1'b0);
        rd(ADDR_LIVE);
        chk("live", v[0], 1'b1);
        wr(ADDR_FLAGS, 32'h1);
        rd(ADDR_FLAGS);
        chk("latch", v[0], 1'b1);
        flt.batt_below <= 1'b0;
        wr(ADDR_FLAGS, 32'h1);
        rd(ADDR_FLAGS);
        chk("latch", v[0], 1'b0);
        flt.io_warn <= 1'b1;
        flt.io_ov <= 1'b1;
        wt(3);
        chk("mode", mode, MODE_NORMAL);
        chk("fail", fail, 1'b0);
        rd(ADDR_FLAGS);
        chk("ov_warn", {v[5], v[2]}, 2'h3);
        flt.io_ov <= 1'b0;
        wr(ADDR_FLAGS, 32'h24);
        wr(ADDR_CTRL, 32'h11);
        flt.io_ov <= 1'b1;
        wt(3);
        chk("mode", mode, MODE_RESTART);
        chk("fail", fail, 1'b1);
        wt(RESET_DELAY_CYC + 10);
        chk("mode", mode, MODE_NORMAL);
        rd(ADDR_CTRL);
        chk("ov_rst", v[4], 1'b0);
        flt.io_ov <= 1'b0;
        wr(ADDR_FLAGS, 32'h20);
        wr(ADDR_CTRL, 32'h7e9);
        wt(2);
        chk("boost", boost_en, 1'b1);
        chk("ext_en", xreg, 1'b1);
        chk("can_en", can_en, 4'hf);
        chk("main_en", mreg, 1'b1);
        flt.boost_off_cross <= 1'b1;
        wt(2);
        chk("boost", boost_en, 1'b0);
        flt.boost_off_cross <= 1'b0;
        flt.boost_on_cross <= 1'b1;
        wt(2);
        chk("boost", boost_en, 1'b1);
        flt.boost_on_cross <= 1'b0;
        flt.boost_tsd <= 1'b1;
        flt.ext_tsd <= 1'b1;
        flt.can_tsd <= 4'h2;
        wt(2);
        chk("boost", boost_en, 1'b0);
        chk("ext_en", xreg, 1'b0);
        chk("can_en", can_en, 4'hd);
        flt.boost_tsd <= 1'b0;
        flt.ext_tsd <= 1'b0;
        flt.can_tsd <= 4'h0;
        wt(2);
        chk("boost", boost_en, 1'b0);
        chk("ext_en", xreg, 1'b0);
        chk("can_en", can_en, 4'hf);
        rd(ADDR_FLAGS);
        chk("cut_flag", v[1], 1'b1);
        chk("tsd_flags", v[16:8], 9'h053);
        wr(ADDR_FLAGS, 32'h1ffff);
        rd(ADDR_FLAGS);
        chk("flags", v, 32'h0);
        for (int i = 1; i <= 4; i++)
        begin
            @(posedge sys_clk_i);
            flt.io_uv <= 1'b1;
            @(posedge sys_clk_i);
            flt.io_uv <= 1'b0;
            wt(2);
            if (i < 4)
            begin
                chk("mode", mode, MODE_RESTART);
                chk("rst_n", rst_n, 1'b0);
                rd(ADDR_LIVE);
                chk("count", v[3:1], i);
                wt(RESET_DELAY_CYC + 10);
            end
        end
        chk("mode", mode, MODE_FAILSAFE);
        chk("wake_en", wake_en, 1'b1);
        chk("fail", fail, 1'b1);
        rd(ADDR_FLAGS);
        chk("uv_fs", v[4:3], 2'h3);
        rd(ADDR_LIVE);
        chk("count", v[3:1], 3'h0);
        chk("timeouts", mcu.tmo, 0);
        stop_test();
    end
endmodule : test_supply_fault_supervisor
